// *** inc/bcc_pkg.sv ***
// Purpose: Shared constants of the BCD calendar clock.
// Assumes: 10 MHz system clock; slow ticks made from it.
// Notes: Offsets are byte addresses on the register port.
package bcc_pkg;
  localparam int unsigned CLK_HZ = 32'h0098_9680; // 10 MHz
  localparam int unsigned SLCK_HZ = 32'h0000_8000; // 32.768 kHz
  localparam logic [14:0] SEC_LAST = 15'h7fff;
  // About 4 ms worth of slow ticks
  localparam logic [14:0] CORR_TICKS = 15'h0080;
  localparam logic [4:0] CORR_BASE = 5'h14;
  localparam logic [4:0] CORR_STEP = 5'h13;
  localparam logic [7:0] OFS_CR = 8'h00;
  localparam logic [7:0] OFS_MR = 8'h04;
  localparam logic [7:0] OFS_TIM = 8'h08;
  localparam logic [7:0] OFS_CAL = 8'h0c;
  localparam logic [7:0] OFS_SR = 8'h18;
  localparam logic [7:0] OFS_SCCR = 8'h1c;
  localparam logic [7:0] OFS_VER = 8'h2c;
  localparam int CR_TIM = 0;
  localparam int CR_CAL = 1;
  localparam int MR_H12 = 0;
  localparam int MR_NEG = 4;
  localparam int MR_CORR = 8;
  localparam int MR_HIGH = 15;
  localparam int MR_SELA = 16;
  localparam int MR_SELB = 20;
  localparam int SR_ACK = 0;
  localparam int SR_ALM = 1;
  localparam int SR_SEC = 2;
  localparam int SR_ERR = 5;
  localparam int TIM_SEC = 0;
  localparam int TIM_MIN = 8;
  localparam int TIM_HOUR = 16;
  localparam int TIM_PM = 22;
  localparam logic [31:0] CAL_RST = 32'h01a1_1020;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] H12_MAX = 8'h12;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [6:0] CENT_LO = 7'h19;
  localparam logic [6:0] CENT_HI = 7'h20;
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_1HZ = 3'h1;
  localparam logic [2:0] SEL_512HZ = 3'h4;
  localparam logic [2:0] SEL_ALARM = 3'h6;
endpackage

// *** inc/bcc_tick_if.sv ***
// Purpose: Calibration setting and tick bundle to the prescaler.
// Assumes: Single clock domain.
// Notes: wave is {512 Hz, 64 Hz, 32 Hz, 1 Hz}.
interface bcc_tick_if;
  logic [6:0] corr;
  logic high;
  logic neg;
  logic sec_tick;
  logic [3:0] wave;
  modport src (input corr, high, neg, output sec_tick, wave);
  modport snk (output corr, high, neg, input sec_tick, wave);
endinterface

// *** hw/bcc_prescaler.sv ***
// Purpose: Slow tick, calibrated 1 Hz divider and square waves.
// Assumes: STEP_P out of CLK_HZ sets the slow tick rate.
// Notes: Larger STEP_P only speeds up simulation.
module bcc_prescaler #(
  parameter logic [23:0] STEP_P = 24'h00_8000 // Slow rate in Hz
) (
  input wire logic mclk_i, // System clock
  input wire logic reset_n_i, // Async reset, active low
  bcc_tick_if.src tk // Calibration in, ticks out
);
  import bcc_pkg::*;
  localparam logic [24:0] WRAP = 25'(CLK_HZ);
  logic [23:0] ph_r;
  logic slow_r;
  logic [14:0] cnt_r;
  logic [7:0] hold_r;
  logic [11:0] since_r;
  logic sec_r;
  logic [3:0] wave_r;
  logic [15:0] len_r;
  wire [24:0] ph_sum = {1'b0, ph_r} + {1'b0, STEP_P};
  wire ph_wrap = ph_sum >= WRAP;
  wire [24:0] ph_left = ph_sum - WRAP;
  // Spacing 1 + (20 - 19*high) * corr seconds
  wire [4:0] mult = CORR_BASE - (tk.high ? CORR_STEP : 5'h00);
  wire [11:0] interval = 12'h001 + ({7'h00, mult} * {5'h00, tk.corr});
  wire corr_en = tk.corr != 7'h00;
  // Compare with >= so a shorter interval written on the fly still fires
  wire corr_now = corr_en && ((since_r + 12'h001) >= interval);
  wire stretch = corr_now && !tk.neg;
  wire shrink = corr_now && tk.neg;
  wire at_last = cnt_r == SEC_LAST;
  wire in_hold = stretch && at_last && (hold_r != CORR_TICKS[7:0]);
  wire early = shrink && (cnt_r == (SEC_LAST - CORR_TICKS));
  wire sec_end = slow_r && ((at_last && !in_hold) || early);
  wire [15:0] len_exp = stretch ? 16'({1'b0, SEC_LAST}) + 16'h0001 + {1'b0, CORR_TICKS} :
                        shrink ? 16'({1'b0, SEC_LAST}) + 16'h0001 - {1'b0, CORR_TICKS} :
                        16'({1'b0, SEC_LAST}) + 16'h0001;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph_r <= 24'h00_0000;
      slow_r <= 1'b0;
      sec_r <= 1'b0;
      wave_r <= 4'h0;
    end else begin
      ph_r <= ph_wrap ? ph_left[23:0] : ph_sum[23:0];
      slow_r <= ph_wrap;
      sec_r <= sec_end;
      // Free running; no power state gates these taps
      wave_r <= {cnt_r[5], cnt_r[8], cnt_r[9], cnt_r[14]};
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 15'h0000;
      hold_r <= 8'h00;
      since_r <= 12'h000;
      len_r <= 16'h0000;
    end else if (sec_end) begin
      cnt_r <= 15'h0000;
      hold_r <= 8'h00;
      since_r <= (corr_now || !corr_en) ? 12'h000 : since_r + 12'h001;
      len_r <= 16'h0000;
    end else if (slow_r) begin
      len_r <= len_r + 16'h0001;
      if (at_last) begin
        hold_r <= hold_r + 8'h01;
      end else begin
        cnt_r <= cnt_r + 15'h0001;
      end
    end
  end

  assign tk.sec_tick = sec_r;
  assign tk.wave = wave_r;

  corr_len_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    sec_end |-> (len_r + 16'h0001) == len_exp)
    else $error("Second length does not match correction");
endmodule

// *** hw/bcc_top.sv ***
// Purpose: BCD time and calendar clock with update handshake and calibration.
// Assumes: Register strobes are one cycle; read data follow one cycle later.
// Notes: Alarm matching is outside; alarm_hit_i reports a match.
module bcc_top #(
  parameter logic [23:0] STEP_P = 24'(bcc_pkg::SLCK_HZ) // Slow tick rate
) (
  input wire logic mclk_i, // System clock, 10 MHz
  input wire logic reset_n_i, // Async reset, active low
  input wire logic [7:0] reg_addr_i, // Register byte address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic alarm_hit_i, // Alarm match pulse
  output logic trig_all_o, // Trigger for all ADC channels
  output logic trig_last_o // Trigger for last ADC channel
);
  import bcc_pkg::*;
  // Bound on request-to-acknowledge wait, in system cycles
  localparam int unsigned SLOW_CYC = CLK_HZ / int'(STEP_P) + 1;
  localparam int unsigned ACK_MAX_CYC =
    (int'(SEC_LAST) + int'(CORR_TICKS) + 3) * SLOW_CYC;

  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] max);
    return (v[3:0] <= 4'h9) && (v <= max);
  endfunction
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  function automatic logic [5:0] mdays(input logic [4:0] mon,
                                       input logic [7:0] yr,
                                       input logic [6:0] cen);
    logic leap;
    leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
            (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) &&
           !(cen == CENT_LO && yr == 8'h00);
    return (mon == 5'h02) ? (leap ? 6'h29 : 6'h28) :
           (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) ? 6'h30 : 6'h31;
  endfunction
  function automatic logic trig_pick(input logic [2:0] sel, input logic [3:0] wv,
                                     input logic alm);
    logic [2:0] idx;
    idx = sel - SEL_1HZ;
    return (sel == SEL_ALARM) ? alm :
           (sel >= SEL_1HZ && sel <= SEL_512HZ) ? wv[idx[1:0]] : 1'b0;
  endfunction

  logic ctl_tim_r;
  logic ctl_cal_r;
  logic hr12_r;
  logic neg_r;
  logic high_r;
  logic [6:0] corr_r;
  logic [2:0] sel_a_r;
  logic [2:0] sel_b_r;
  logic [6:0] sec_r;
  logic [6:0] min_r;
  logic [5:0] hour_r;
  logic [6:0] cent_r;
  logic [7:0] year_r;
  logic [4:0] mon_r;
  logic [2:0] day_r;
  logic [5:0] date_r;
  logic tim_halt_r;
  logic cal_halt_r;
  logic ack_r;
  logic alm_r;
  logic secf_r;
  logic err_r;
  logic nv_tim_r;
  logic [31:0] rdata_r;
  logic trig_a_r;
  logic trig_b_r;
  logic [23:0] wait_r;

  bcc_tick_if tk();
  bcc_prescaler #(.STEP_P(STEP_P)) u_pre (
    .mclk_i (mclk_i),
    .reset_n_i (reset_n_i),
    .tk (tk)
  );

  assign tk.corr = corr_r;
  assign tk.high = high_r;
  assign tk.neg = neg_r;

  // Register decode
  wire [31:0] wd = reg_wdata_i;
  wire wr_cr = reg_wr_i && (reg_addr_i == OFS_CR);
  wire wr_mr = reg_wr_i && (reg_addr_i == OFS_MR);
  wire wr_tim = reg_wr_i && (reg_addr_i == OFS_TIM);
  wire wr_cal = reg_wr_i && (reg_addr_i == OFS_CAL);
  wire wr_sccr = reg_wr_i && (reg_addr_i == OFS_SCCR);
  wire clr_ack = wr_sccr && wd[SR_ACK];
  wire clr_alm = wr_sccr && wd[SR_ALM];
  wire clr_sec = wr_sccr && wd[SR_SEC];
  wire clr_err = wr_sccr && wd[SR_ERR];

  // Time entry check
  wire [6:0] w_sec = wd[TIM_SEC +: 7];
  wire [6:0] w_min = wd[TIM_MIN +: 7];
  wire [5:0] w_hour = wd[TIM_HOUR +: 6];
  wire w_pm = wd[TIM_PM];
  wire sec_in_ok = bcd_ok({1'b0, w_sec}, SEC_MAX);
  wire hour_in_ok = hr12_r ?
    (bcd_ok({2'b00, w_hour}, H12_MAX) && w_hour != 6'h00) :
    (bcd_ok({2'b00, w_hour}, HOUR_MAX) && !w_pm);
  // 01..11 PM to 13..23 in BCD without a binary round trip
  wire [5:0] h_pm = w_hour[4] ? {2'b10, w_hour[3:0] + 4'h2} :
                    w_hour[3] ? {2'b10, w_hour[3:0] - 4'h8} :
                    {2'b01, w_hour[3:0] + 4'h2};
  wire [5:0] h24 = !hr12_r ? w_hour :
                   (w_hour == H12_MAX[5:0]) ? (w_pm ? H12_MAX[5:0] : 6'h00) :
                   (w_pm ? h_pm : w_hour);
  // Writes only count once the matching counters are halted
  wire tim_try = wr_tim && tim_halt_r;
  wire tim_load = tim_try && sec_in_ok && hour_in_ok;
  // Remaining calendar entry checks are outside this block
  wire cal_load = wr_cal && cal_halt_r;

  // Counting chain
  wire tick = tk.sec_tick && !tim_halt_r;
  wire cal_run = !cal_halt_r;
  wire [7:0] sec_inc = bcd_inc({1'b0, sec_r});
  wire [7:0] min_inc = bcd_inc({1'b0, min_r});
  wire [7:0] hour_inc = bcd_inc({2'b00, hour_r});
  wire [7:0] date_inc = bcd_inc({2'b00, date_r});
  wire [7:0] mon_inc = bcd_inc({3'b000, mon_r});
  wire [7:0] year_inc = bcd_inc(year_r);
  wire [7:0] cent_inc = bcd_inc({1'b0, cent_r});
  wire [5:0] dim = mdays(mon_r, year_r, cent_r);
  wire sec_wrap = sec_r == SEC_MAX[6:0];
  wire min_go = tick && sec_wrap;
  wire hour_go = min_go && (min_r == SEC_MAX[6:0]);
  wire day_go = hour_go && (hour_r == HOUR_MAX[5:0]) && cal_run;
  wire mon_go = day_go && (date_r == dim);
  wire year_go = mon_go && (mon_r == MON_MAX[4:0]);
  wire cent_go = year_go && (year_r == YEAR_MAX);

  // Permanent consistency check of the live counters
  wire cnt_ok = bcd_ok({1'b0, sec_r}, SEC_MAX) && bcd_ok({1'b0, min_r}, SEC_MAX) &&
                bcd_ok({2'b00, hour_r}, HOUR_MAX) &&
                (cent_r == CENT_LO || cent_r == CENT_HI) &&
                bcd_ok(year_r, YEAR_MAX) &&
                bcd_ok({3'b000, mon_r}, MON_MAX) && (mon_r != 5'h00) &&
                bcd_ok({2'b00, date_r}, {2'b00, dim}) && (date_r != 6'h00) &&
                (day_r != 3'h0);

  // Sticky flags: a set in the clearing cycle wins
  wire err_nxt = !cnt_ok || (err_r && !clr_err);
  wire ack_set = tk.sec_tick &&
    ((ctl_tim_r && !tim_halt_r) || (ctl_cal_r && !cal_halt_r));
  wire ack_nxt = ack_set || (ack_r && !clr_ack);
  wire alm_nxt = alarm_hit_i || (alm_r && !clr_alm);
  wire secf_nxt = tk.sec_tick || (secf_r && !clr_sec);
  wire nv_nxt = tim_try ? !tim_load : nv_tim_r;
  wire pend = (ctl_tim_r && !tim_halt_r) || (ctl_cal_r && !cal_halt_r);

  // Read mux
  wire [31:0] mr_word = {9'h000, sel_b_r, 1'b0, sel_a_r, high_r, corr_r,
                         3'h0, neg_r, 3'h0, hr12_r};
  wire [31:0] tim_word = {10'h000, hour_r, 1'b0, min_r, 1'b0, sec_r};
  wire [31:0] cal_word = {2'b00, date_r, day_r, mon_r, year_r, 1'b0, cent_r};
  wire [31:0] sr_word = {26'h000_0000, err_r, 2'b00, secf_r, alm_r, ack_r};
  wire [31:0] rd_mux =
    (reg_addr_i == OFS_CR) ? {30'h0000_0000, ctl_cal_r, ctl_tim_r} :
    (reg_addr_i == OFS_MR) ? mr_word :
    (reg_addr_i == OFS_TIM) ? tim_word :
    (reg_addr_i == OFS_CAL) ? cal_word :
    (reg_addr_i == OFS_SR) ? sr_word :
    (reg_addr_i == OFS_VER) ? {31'h0000_0000, nv_tim_r} :
    32'h0000_0000;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_tim_r <= 1'b0;
      ctl_cal_r <= 1'b0;
    end else if (wr_cr) begin
      ctl_tim_r <= wd[CR_TIM];
      ctl_cal_r <= wd[CR_CAL];
    end
  end

  // Mode word takes writes at any time, clock keeps running
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hr12_r <= 1'b0;
      neg_r <= 1'b0;
      high_r <= 1'b0;
      corr_r <= 7'h00;
      sel_a_r <= SEL_OFF;
      sel_b_r <= SEL_OFF;
    end else if (wr_mr) begin
      hr12_r <= wd[MR_H12];
      neg_r <= wd[MR_NEG];
      high_r <= wd[MR_HIGH];
      corr_r <= wd[MR_CORR +: 7];
      sel_a_r <= wd[MR_SELA +: 3];
      sel_b_r <= wd[MR_SELB +: 3];
    end
  end

  // Halt follows the request at a second boundary, drops with it
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tim_halt_r <= 1'b0;
      cal_halt_r <= 1'b0;
    end else begin
      tim_halt_r <= ctl_tim_r && (tim_halt_r || tk.sec_tick);
      cal_halt_r <= ctl_cal_r && (cal_halt_r || tk.sec_tick);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sec_r <= 7'h00;
      min_r <= 7'h00;
      hour_r <= 6'h00;
    end else if (tim_load) begin
      sec_r <= w_sec;
      min_r <= w_min;
      hour_r <= h24;
    end else if (tick) begin
      sec_r <= sec_wrap ? 7'h00 : sec_inc[6:0];
      if (min_go) begin
        min_r <= (min_r == SEC_MAX[6:0]) ? 7'h00 : min_inc[6:0];
      end
      if (hour_go) begin
        hour_r <= (hour_r == HOUR_MAX[5:0]) ? 6'h00 : hour_inc[5:0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cent_r <= CAL_RST[6:0];
      year_r <= CAL_RST[15:8];
      mon_r <= CAL_RST[20:16];
      day_r <= CAL_RST[23:21];
      date_r <= CAL_RST[29:24];
    end else if (cal_load) begin
      cent_r <= wd[6:0];
      year_r <= wd[15:8];
      mon_r <= wd[20:16];
      day_r <= wd[23:21];
      date_r <= wd[29:24];
    end else if (day_go) begin
      day_r <= (day_r == 3'h7) ? 3'h1 : day_r + 3'h1;
      date_r <= mon_go ? 6'h01 : date_inc[5:0];
      if (mon_go) begin
        mon_r <= year_go ? 5'h01 : mon_inc[4:0];
      end
      if (year_go) begin
        year_r <= cent_go ? 8'h00 : year_inc;
      end
      if (cent_go) begin
        cent_r <= cent_inc[6:0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      alm_r <= 1'b0;
      secf_r <= 1'b0;
      err_r <= 1'b0;
      nv_tim_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      alm_r <= alm_nxt;
      secf_r <= secf_nxt;
      err_r <= err_nxt;
      nv_tim_r <= nv_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= 32'h0000_0000;
      trig_a_r <= 1'b0;
      trig_b_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
      trig_a_r <= trig_pick(sel_a_r, tk.wave, alm_r);
      trig_b_r <= trig_pick(sel_b_r, tk.wave, alm_r);
    end
  end

  assign reg_rdata_o = rdata_r;
  assign trig_all_o = trig_a_r;
  assign trig_last_o = trig_b_r;

  // Wait counter seen only by the acknowledge bound check
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_r <= 24'h00_0000;
    end else begin
      wait_r <= pend ? wait_r + 24'h00_0001 : 24'h00_0000;
    end
  end

  sec_entry_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    tim_try && !sec_in_ok |=> nv_tim_r && $stable(sec_r))
    else $error("Bad seconds value was loaded");
  hour_conv_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    tim_load && hr12_r && w_pm && (w_hour == 6'h01) |=> hour_r == 6'h13)
    else $error("12-hour PM value not stored as 24-hour");
  pm_range_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    tim_try && !hr12_r && w_pm |=> nv_tim_r && $stable(hour_r))
    else $error("PM bit accepted in 24-hour mode");
  err_set_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !cnt_ok |=> err_r)
    else $error("Invalid counter did not raise error");
  err_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clr_err && cnt_ok |=> !err_r)
    else $error("Error flag not cleared");
  err_reset_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    clr_err && !cnt_ok |=> err_r)
    else $error("Error flag lost while cause persists");
  err_keep_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    err_r && !clr_err |=> err_r)
    else $error("Error flag dropped without clear");
  ack_time_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    pend |-> wait_r <= 24'(ACK_MAX_CYC))
    else $error("Update acknowledge late");
  ack_halt_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ack_set |=> ack_r && (tim_halt_r || cal_halt_r))
    else $error("Acknowledge without halted counters");
  tim_stop_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    tk.sec_tick && tim_halt_r && !reg_wr_i |=> $stable(sec_r) && $stable(date_r))
    else $error("Counters moved during time update");
  cal_only_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    tk.sec_tick && cal_halt_r && !tim_halt_r && !reg_wr_i && (sec_r == 7'h00) |=> sec_r == 7'h01)
    else $error("Time stopped by calendar update");
  trig_off_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    sel_a_r == SEL_OFF |=> !trig_all_o)
    else $error("Trigger not held low when off");
  alarm_copy_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    sel_b_r == SEL_ALARM |=> trig_last_o == $past(alm_r))
    else $error("Trigger does not follow alarm flag");
endmodule

// *** sim/bcc_adc_sink.sv ***
// Purpose: ADC-side model that counts trigger rising edges.
// Assumes: Triggers are level outputs in the system clock domain.
// Notes: Counters wrap; the bench only uses differences.
module bcc_adc_sink (
  input wire logic mclk_i, // System clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic trig_all_i, // Trigger for all channels
  input wire logic trig_last_i, // Trigger for last channel
  output logic [15:0] all_edges_o, // Rising edges on trig_all
  output logic [15:0] last_edges_o // Rising edges on trig_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic all_r;
  logic last_r;
  // Two independent counters, one per trigger
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      all_r <= 1'b0;
      last_r <= 1'b0;
      all_edges_o <= 16'h0000;
      last_edges_o <= 16'h0000;
    end else begin
      all_r <= trig_all_i;
      last_r <= trig_last_i;
      if (trig_all_i && !all_r) all_edges_o <= all_edges_o + 16'h0001;
      if (trig_last_i && !last_r) last_edges_o <= last_edges_o + 16'h0001;
    end
  end
endmodule

// *** sim/bcd_calendar_clock_update_calib_test.sv ***
// Purpose: Self-checking bench for the BCD calendar clock.
// Assumes: Fast slow-tick parameter, so one second is 32768 cycles.
// Notes: Calibration timing and roll-over beyond the minute are not exercised here.
module bcd_calendar_clock_update_calib_test;
  import bcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i;
  logic reset_n_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic alarm_hit_i;
  logic trig_all_o;
  logic trig_last_o;
  logic [15:0] all_edges;
  logic [15:0] last_edges;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [31:0] TMASK = 32'h003f_7f7f;

  bcc_top #(.STEP_P(24'h98_9680)) u_bcc_top (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .alarm_hit_i(alarm_hit_i),
    .trig_all_o(trig_all_o), .trig_last_o(trig_last_o));

  bcc_adc_sink u_bcc_adc_sink (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .trig_all_i(trig_all_o),
    .trig_last_i(trig_last_o), .all_edges_o(all_edges), .last_edges_o(last_edges));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask

  task automatic t_reset();
    logic [7:0] ra [7];
    logic [31:0] rv [7];
    ra = '{OFS_CR, OFS_MR, OFS_TIM, OFS_CAL, OFS_SR, OFS_SCCR, 8'h30};
    rv = '{32'h0, 32'h0, 32'h0, CAL_RST, 32'h0, 32'h0, 32'h0};
    foreach (ra[i]) rchk(ra[i], '1, rv[i]);
    wr(8'h30, 32'hffff_ffff);
    rchk(8'h30, '1, 32'h0);
  endtask

  task automatic t_wave();
    logic [15:0] e;
    wr(OFS_MR, 32'h0064_8510);
    rchk(OFS_MR, '1, 32'h0064_8510);
    repeat (4) @(posedge mclk_i);
    e = all_edges;
    repeat (640) @(posedge mclk_i);
    e = all_edges - e;
    chk(32'(e >= 16'h0009 && e <= 16'h000b), 32'h1);
    #1;
    chk(32'(trig_last_o), 32'h0);
    @(posedge mclk_i);
    alarm_hit_i <= 1'b1;
    @(posedge mclk_i);
    alarm_hit_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(32'(trig_last_o), 32'h1);
    rchk(OFS_SR, 32'h2, 32'h2);
    wr(OFS_SCCR, 32'h2);
    repeat (3) @(posedge mclk_i);
    #1;
    chk(32'(trig_last_o), 32'h0);
    wr(OFS_MR, 32'h0);
    repeat (4) @(posedge mclk_i);
    e = all_edges;
    repeat (640) @(posedge mclk_i);
    chk(32'(all_edges - e), 32'h0);
  endtask

  task automatic t_update();
    logic [31:0] d;
    int n;
    // Calendar too, so the error scenario can load a calendar word
    wr(OFS_CR, 32'h3);
    d = 32'h0;
    for (n = 0; n < 20000 && d[SR_ACK] !== 1'b1; n++) rd(OFS_SR, d);
    chk(d & 32'h1, 32'h1);
    chk(32'(n <= 16390), 32'h1);
    wr(OFS_SCCR, 32'h1);
    rchk(OFS_SR, 32'h1, 32'h0);
    wr(OFS_MR, 32'h1);
    wr(OFS_TIM, 32'h0041_0030);
    rchk(OFS_TIM, TMASK, 32'h0013_0030);
    rchk(OFS_VER, 32'h1, 32'h0);
    wr(OFS_TIM, 32'h0041_0060);
    rchk(OFS_VER, 32'h1, 32'h1);
    rchk(OFS_TIM, TMASK, 32'h0013_0030);
    wr(OFS_TIM, 32'h0001_0059);
    rchk(OFS_TIM, TMASK, 32'h0001_0059);
    wr(OFS_TIM, 32'h0013_0000);
    rchk(OFS_VER, 32'h1, 32'h1);
  endtask

  // Bad month while halted; error must persist until cause is removed
  task automatic t_error();
    wr(OFS_CAL, 32'h01b3_1020);
    rchk(OFS_SR, 32'h20, 32'h20);
    wr(OFS_SCCR, 32'h20);
    rchk(OFS_SR, 32'h20, 32'h20);
    wr(OFS_CAL, CAL_RST);
    rchk(OFS_CAL, '1, CAL_RST);
    wr(OFS_SCCR, 32'h20);
    rchk(OFS_SR, 32'h20, 32'h0);
    wr(OFS_CR, 32'h0);
  endtask

  // Counting resumes; the next second tick takes 01:00:59 to 01:01:00
  task automatic t_resume();
    logic [31:0] d;
    int n;
    wr(OFS_SCCR, 32'h4);
    rchk(OFS_SR, 32'h4, 32'h0);
    d = 32'h0;
    for (n = 0; n < 20000 && d[SR_SEC] !== 1'b1; n++) rd(OFS_SR, d);
    chk(d & 32'h4, 32'h4);
    wr(OFS_SCCR, 32'h4);
    rchk(OFS_SR, 32'h4, 32'h0);
    rchk(OFS_TIM, TMASK, 32'h0001_0100);
  endtask

  // Tests need about two seconds of 32768 cycles; margin on top
  initial begin
    repeat (80000) @(posedge mclk_i);
    bad_count++;
    close_out();
  end

  initial begin
    reset_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    alarm_hit_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_wave();
    t_update();
    t_error();
    t_resume();
    close_out();
  end
endmodule
